// file: osi_pkg.sv
package osi_pkg;

    localparam int OSI_DATA_W = 8;
    localparam int OSI_ADDR_W = 7;
    localparam int OSI_FILE_DEPTH = 128;
    localparam logic [7:0] OSI_ACC_RST = 8'h00;
    localparam logic [7:0] OSI_ONE = 8'h01;
    localparam logic [7:0] OSI_ZERO = 8'h00;
    localparam logic OSI_DEST_ACC = 1'b0;
    localparam logic OSI_DEST_FILE = 1'b1;
    localparam int OSI_MSB = 7;
    localparam int OSI_LSB = 0;

    typedef enum logic [2:0] {
        OSI_OP_NONE,
        OSI_OP_OR_REG,
        OSI_OP_OR_LIT,
        OSI_OP_SHL,
        OSI_OP_SHR,
        OSI_OP_INC_SKIP
    } osi_op_e;

    typedef enum logic [1:0] {
        OSI_IDLE,
        OSI_EXEC,
        OSI_SKIP
    } osi_state_e;

    typedef struct packed {
        osi_op_e op;
        logic [6:0] addr;
        logic dest;
        logic [7:0] literal;
    } osi_instr_s;

    typedef struct packed {
        osi_state_e state;
        osi_instr_s instr;
        logic [7:0] acc;
        logic zero;
        logic carry;
        logic busy;
        logic done;
        logic skipped;
        logic wr_en;
        logic [6:0] wr_addr;
        logic [7:0] wr_data;
    } osi_state_s;

endpackage : osi_pkg

// file: osi_file_ram.sv
`timescale 1ns/1ps
`default_nettype none
module osi_file_ram (
    input wire logic clk_sys, // core clock
    input wire logic [6:0] rd_addr, // read address
    output logic [7:0] rd_data, // registered read data
    input wire logic wr_en, // write strobe
    input wire logic [6:0] wr_addr, // write address
    input wire logic [7:0] wr_data // write data
);
    import osi_pkg::*;

    logic [7:0] mem [OSI_FILE_DEPTH];

    // no reset: contents are undefined until written, as real sram would be
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        // a write landing on the edge that reads the same word is passed on,
        // so an instruction issued in the done cycle sees the fresh value
        if (wr_en && wr_addr == rd_addr) begin
            rd_data <= wr_data;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule : osi_file_ram
`default_nettype wire

// file: osi_core.sv
// How it works
// - register-or: acc or file, zero updated
// - destination bit: 0 accumulator, 1 file
// - left shift: bit7 to carry, zero in
// - right shift: bit0 to carry, zero in
// - increment file register, flags untouched
// - zero increment result skips next instruction
// - literal-or into accumulator, zero updated
`timescale 1ns/1ps
`default_nettype none
module osi_core (
    input wire logic clk_sys, // 50 MHz core clock
    input wire logic rstn, // async reset, active low
    input wire logic issue, // one-cycle instruction issue pulse
    input wire osi_pkg::osi_instr_s instr, // decoded instruction, held with issue
    output logic ready, // can take an instruction
    output logic done, // one-cycle completion pulse
    output logic skipped, // one-cycle pulse: a slot became a no-op
    output logic [7:0] acc, // accumulator
    output logic zero, // zero flag
    output logic carry, // carry flag
    output logic file_wr_en, // file write strobe (registered)
    output logic [6:0] file_wr_addr, // file write address
    output logic [7:0] file_wr_data // file write data
);
    import osi_pkg::*;

    osi_state_s r;
    osi_state_s next_r;
    logic [7:0] file_rd;
    logic [7:0] operand;
    logic [7:0] result;
    logic upd_zero;
    logic upd_carry;
    logic new_carry;
    logic [6:0] rd_addr;

    // reading in the issue cycle lets the ram register deliver in exec
    assign rd_addr = issue ? instr.addr : r.instr.addr;

    osi_file_ram u_ram (
        .clk_sys(clk_sys),
        .rd_addr(rd_addr),
        .rd_data(file_rd),
        .wr_en(r.wr_en),
        .wr_addr(r.wr_addr),
        .wr_data(r.wr_data)
    );

    // a write just committed to the same address must be seen by the next read
    assign operand = (r.wr_en && r.wr_addr == r.instr.addr) ? r.wr_data : file_rd;

    always_comb begin
        result = OSI_ZERO;
        upd_zero = 1'b0;
        upd_carry = 1'b0;
        new_carry = 1'b0;
        unique case (r.instr.op)
            OSI_OP_OR_REG: begin
                result = r.acc | operand;
                upd_zero = 1'b1;
            end
            OSI_OP_OR_LIT: begin
                result = r.acc | r.instr.literal;
                upd_zero = 1'b1;
            end
            OSI_OP_SHL: begin
                result = {operand[OSI_MSB-1:OSI_LSB], 1'b0};
                new_carry = operand[OSI_MSB];
                upd_zero = 1'b1;
                upd_carry = 1'b1;
            end
            OSI_OP_SHR: begin
                result = {1'b0, operand[OSI_MSB:OSI_LSB+1]};
                new_carry = operand[OSI_LSB];
                upd_zero = 1'b1;
                upd_carry = 1'b1;
            end
            OSI_OP_INC_SKIP: begin
                result = operand + OSI_ONE;
            end
            default: begin
                result = OSI_ZERO;
            end
        endcase
    end

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        next_r.skipped = 1'b0;
        next_r.wr_en = 1'b0;
        unique case (r.state)
            OSI_IDLE: begin
                if (issue) begin
                    next_r.instr = instr;
                    next_r.state = OSI_EXEC;
                    next_r.busy = 1'b1;
                end
            end
            OSI_EXEC: begin
                if (upd_zero) begin
                    next_r.zero = (result == OSI_ZERO);
                end
                if (upd_carry) begin
                    next_r.carry = new_carry;
                end
                if (r.instr.op == OSI_OP_OR_LIT || r.instr.dest == OSI_DEST_ACC) begin
                    next_r.acc = result;
                end else begin
                    next_r.wr_en = 1'b1;
                    next_r.wr_addr = r.instr.addr;
                    next_r.wr_data = result;
                end
                if (r.instr.op == OSI_OP_INC_SKIP && result == OSI_ZERO) begin
                    next_r.state = OSI_SKIP;
                end else begin
                    next_r.state = OSI_IDLE;
                    next_r.busy = 1'b0;
                    next_r.done = 1'b1;
                end
            end
            OSI_SKIP: begin
                // the following slot is spent as a no-op, giving two cycles
                next_r.state = OSI_IDLE;
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
                next_r.skipped = 1'b1;
            end
            default: begin
                next_r.state = OSI_IDLE;
                next_r.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            r <= '{state: OSI_IDLE, instr: '0, acc: OSI_ACC_RST, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign ready = ~r.busy;
    assign done = r.done;
    assign skipped = r.skipped;
    assign acc = r.acc;
    assign zero = r.zero;
    assign carry = r.carry;
    assign file_wr_en = r.wr_en;
    assign file_wr_addr = r.wr_addr;
    assign file_wr_data = r.wr_data;
endmodule : osi_core
`default_nettype wire

// file: osi_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module osi_core_monitor (
    input wire logic clk_sys, // clock
    input wire logic rstn, // reset
    input wire logic issue, // request
    input wire osi_pkg::osi_instr_s instr, // instruction
    input wire logic ready, // idle
    input wire logic done, // finished
    input wire logic skipped, // no-op slot
    input wire logic [7:0] acc, // accumulator
    input wire logic zero, // zero flag
    input wire logic carry, // carry flag
    input wire logic file_wr_en, // write strobe
    input wire logic [6:0] file_wr_addr, // write address
    input wire logic [7:0] file_wr_data // write data
);
    import osi_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // plain expression, so it may be combined with && like any other term
    logic tk;
    assign tk = issue && ready;
    sequence inc_wrap;
        tk && instr.op == OSI_OP_INC_SKIP && instr.dest ##2 file_wr_en && file_wr_data == 8'h00;
    endsequence
    answer_time_a: assert property (tk |-> ##[2:3] done) else $error("late completion");
    skip_slot_a: assert property (inc_wrap |=> done && skipped) else $error("no skip slot");
    or_lit_a: assert property (tk && instr.op == OSI_OP_OR_LIT |->
        ##2 acc == ($past(acc, 2) | $past(instr.literal, 2))) else $error("literal or wrong");
    or_keep_a: assert property (tk && instr.op == OSI_OP_OR_REG && !instr.dest |->
        ##2 (acc & $past(acc, 2)) == $past(acc, 2)) else $error("or lost bits");
    zero_flag_a: assert property (tk && instr.op != OSI_OP_INC_SKIP && !instr.dest |->
        ##2 zero == (acc == 8'h00)) else $error("zero flag wrong");
    dest_file_a: assert property (tk && instr.dest && instr.op != OSI_OP_OR_LIT |->
        ##2 file_wr_en && file_wr_addr == $past(instr.addr, 2)) else $error("file write missing");
    shl_fill_a: assert property (tk && instr.op == OSI_OP_SHL |->
        ##2 !($past(instr.dest, 2) ? file_wr_data[0] : acc[0])) else $error("left fill wrong");
    shr_fill_a: assert property (tk && instr.op == OSI_OP_SHR |->
        ##2 !($past(instr.dest, 2) ? file_wr_data[7] : acc[7])) else $error("right fill wrong");
    inc_flags_a: assert property (tk && instr.op == OSI_OP_INC_SKIP |=>
        $stable({zero, carry})[*2]) else $error("increment moved flags");
endmodule : osi_core_monitor
`default_nettype wire

// file: tb_or_shift_increment_ops.sv
`timescale 1ns/1ps
`default_nettype none
module tb_or_shift_increment_ops;
    import osi_pkg::*;
    logic clk_sys = 1'b0, rstn = 1'b0, issue = 1'b0, ready, done, skipped, zero, carry, file_wr_en;
    osi_instr_s instr = '0;
    logic [7:0] acc, file_wr_data, wd;
    logic [6:0] file_wr_addr;
    int n_errors = 0, n_checks = 0;
    logic back = 1'b0;
    osi_core i_dut (.clk_sys, .rstn, .issue, .instr, .ready, .done, .skipped, .acc, .zero, .carry,
        .file_wr_en, .file_wr_addr, .file_wr_data);
    initial forever #10 clk_sys = ~clk_sys;
    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task op(input osi_op_e o, input logic [6:0] a, input logic d, input logic [7:0] k, r, input logic z, c, s);
        int n;
        if (!back) @(posedge clk_sys);
        #1 issue = 1'b1;
        instr = '{o, a, d, k};
        wd = 'x;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1 issue = 1'b0;
            if (file_wr_en) wd = file_wr_data;
            n++;
        end while (done !== 1'b1 && n < 5);
        if (done !== 1'b1) begin
            n_errors++;
            complete_run();
        end
        chk("result", r, d ? wd : acc);
        chk("zero", {7'h00, z}, {7'h00, zero});
        chk("carry", {7'h00, c}, {7'h00, carry});
        chk("skipped", {7'h00, s}, {7'h00, skipped});
    endtask : op
    task t_or;
        op(OSI_OP_OR_LIT, 7'h00, 1'b0, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0);
        op(OSI_OP_OR_LIT, 7'h00, 1'b0, 8'h81, 8'h81, 1'b0, 1'b0, 1'b0);
        op(OSI_OP_OR_LIT, 7'h00, 1'b0, 8'h7e, 8'hff, 1'b0, 1'b0, 1'b0);
        op(OSI_OP_OR_REG, 7'h03, 1'b1, 8'h00, 8'hff, 1'b0, 1'b0, 1'b0);
        op(OSI_OP_OR_REG, 7'h05, 1'b1, 8'h00, 8'hff, 1'b0, 1'b0, 1'b0);
        $display("test or ended");
    endtask : t_or
    task t_shift;
        op(OSI_OP_SHL, 7'h03, 1'b1, 8'h00, 8'hfe, 1'b0, 1'b1, 1'b0);
        op(OSI_OP_SHR, 7'h03, 1'b0, 8'h00, 8'h7f, 1'b0, 1'b0, 1'b0);
        $display("test shift ended");
    endtask : t_shift
    task t_inc;
        op(OSI_OP_INC_SKIP, 7'h05, 1'b1, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1);
        op(OSI_OP_INC_SKIP, 7'h05, 1'b0, 8'h00, 8'h01, 1'b0, 1'b0, 1'b0);
        $display("test increment ended");
    endtask : t_inc
    task t_zero;
        op(OSI_OP_SHR, 7'h05, 1'b1, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0);
        op(OSI_OP_INC_SKIP, 7'h05, 1'b1, 8'h00, 8'h01, 1'b1, 1'b0, 1'b0);
        op(OSI_OP_SHR, 7'h05, 1'b0, 8'h00, 8'h00, 1'b1, 1'b1, 1'b0);
        op(OSI_OP_OR_REG, 7'h03, 1'b0, 8'h00, 8'hfe, 1'b0, 1'b1, 1'b0);
        $display("test zero ended");
    endtask : t_zero
    task t_back;
        op(OSI_OP_OR_LIT, 7'h00, 1'b0, 8'h01, 8'hff, 1'b0, 1'b1, 1'b0);
        back = 1'b1;
        op(OSI_OP_OR_REG, 7'h03, 1'b1, 8'h00, 8'hff, 1'b0, 1'b1, 1'b0);
        op(OSI_OP_SHR, 7'h03, 1'b0, 8'h00, 8'h7f, 1'b0, 1'b1, 1'b0);
        back = 1'b0;
        $display("test back to back ended");
    endtask : t_back
    initial begin
        repeat (10) @(posedge clk_sys);
        #1 rstn = 1'b1;
        t_or();
        t_shift();
        t_inc();
        t_zero();
        t_back();
        complete_run();
    end
endmodule : tb_or_shift_increment_ops
bind osi_core osi_core_monitor i_mon (.clk_sys, .rstn, .issue, .instr, .ready, .done, .skipped, .acc, .zero,
    .carry, .file_wr_en, .file_wr_addr, .file_wr_data);
`default_nettype wire
